// File: hw/vbi_inserter.sv
`timescale 1ns/10ps
module vbi_inserter
	import vbi_pkg::*;
(
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// video timing
	input  wire logic [2:0]  video_mode,
	input  wire logic        line_start,
	input  wire logic [10:0] line_num,
	input  wire logic        field_even,
	// luma path
	input  wire logic [9:0]  luma_in,
	output logic      [9:0]  luma_out,
	output logic             vbi_insert
);

	function automatic logic reg_mapped(input logic [9:0] idx);
		reg_mapped = (idx == IDX_ED_CTL) || (idx >= IDX_HD_DATA0 && idx <= IDX_HD_DATA2)
			|| (idx >= IDX_TYPEB_LO && idx <= IDX_TYPEB_HI)
			|| (idx >= IDX_SD_CTL && idx <= IDX_SD_DATA2) || (idx == IDX_BLANK_CTL);
	endfunction

	function automatic logic [5:0] crc_step(input logic [5:0] crc, input logic din);
		logic fb;
		fb = din ^ crc[5];
		crc_step = {crc[4:0], 1'b0} ^ (fb ? CRC_TAPS : 6'h00);
	endfunction

	logic [7:0]  ed_ctl_reg;
	logic [7:0]  hd_data_reg [3];
	logic [7:0]  typeb_reg [TYPEB_REGS];
	logic [7:0]  sd_reg [3];
	logic        blank_reg;
	logic        pready_reg;
	logic [31:0] prdata_reg;
	logic        pslverr_reg;

	logic [9:0]  idx;
	logic        access;
	logic        wr_en;
	logic [7:0]  rd_byte;

	assign idx    = paddr[11:2];
	assign access = psel & penable & pready_reg;
	assign wr_en  = access & pwrite & reg_mapped(idx);

	// apb handshake: one wait cycle, then ready
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pready_reg <= 1'b0;
		else
			pready_reg <= psel & penable & ~pready_reg;
	end

	always_comb
	begin
		rd_byte = 8'h00;
		if (idx == IDX_ED_CTL)
			rd_byte = ed_ctl_reg;
		else if (idx >= IDX_HD_DATA0 && idx <= IDX_HD_DATA2)
			rd_byte = hd_data_reg[2'(idx - IDX_HD_DATA0)];
		else if (idx >= IDX_TYPEB_LO && idx <= IDX_TYPEB_HI)
			rd_byte = typeb_reg[5'(idx - IDX_TYPEB_LO)];
		else if (idx >= IDX_SD_CTL && idx <= IDX_SD_DATA2)
			rd_byte = sd_reg[2'(idx - IDX_SD_CTL)];
		else if (idx == IDX_BLANK_CTL)
			rd_byte = {blank_reg, 7'h00};
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_reg  <= 32'h00000000;
			pslverr_reg <= 1'b0;
		end
		else if (psel & penable & ~pready_reg)
		begin
			prdata_reg  <= pwrite ? 32'h00000000 : {24'h000000, rd_byte};
			pslverr_reg <= ~reg_mapped(idx);
		end
		else
		begin
			pslverr_reg <= 1'b0;
		end
	end

	// register writes
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ed_ctl_reg <= REG_RESET;
			blank_reg  <= 1'b0;
			for (int i = 0; i < 3; i++)
			begin
				hd_data_reg[i] <= REG_RESET;
				sd_reg[i]      <= REG_RESET;
			end
			for (int i = 0; i < TYPEB_REGS; i++)
				typeb_reg[i] <= REG_RESET;
		end
		else if (wr_en)
		begin
			if (idx == IDX_ED_CTL)
				ed_ctl_reg <= pwdata[7:0];
			if (idx == IDX_BLANK_CTL)
				blank_reg <= pwdata[WSS_BLANK_BIT];
			for (int i = 0; i < 3; i++)
			begin
				if (idx == IDX_HD_DATA0 + 10'(i))
					hd_data_reg[i] <= pwdata[7:0];
				if (idx == IDX_SD_CTL + 10'(i))
					sd_reg[i] <= pwdata[7:0];
			end
			for (int i = 0; i < TYPEB_REGS; i++)
				if (idx == IDX_TYPEB_LO + 10'(i))
					typeb_reg[i] <= pwdata[7:0];
		end
	end

	// assembled words
	logic [19:0]  hd_raw;
	logic [19:0]  sd_raw;
	logic [135:0] tb_bytes;
	logic [133:0] tb_raw;
	logic [15:0]  ed625_word;
	logic [13:0]  wss_bits;
	logic         is_ntsc;
	logic [19:0]  basic_raw;

	assign hd_raw     = {hd_data_reg[0][3:0], hd_data_reg[1], hd_data_reg[2]}; // R5
	assign sd_raw     = {sd_reg[0][3:0], sd_reg[1], sd_reg[2]};
	assign ed625_word = {hd_data_reg[1], hd_data_reg[2]}; // R2
	assign wss_bits   = {sd_reg[1][5:0], sd_reg[2]}; // R17
	assign is_ntsc    = (video_mode == MODE_NTSC);
	assign basic_raw  = is_ntsc ? sd_raw : hd_raw;

	genvar g;
	generate
		for (g = 0; g < TYPEB_REGS; g++)
		begin : g_tb
			assign tb_bytes[g*8 +: 8] = typeb_reg[g]; // R8
		end
	endgenerate
	assign tb_raw = tb_bytes[135:2];

	// serial check generator, runs for 128 cycles after each line start
	logic [7:0] crc_cnt_reg;
	logic       crc_busy_reg;
	logic [5:0] basic_lfsr_reg;
	logic [5:0] tb_lfsr_reg;
	logic [5:0] basic_crc_reg;
	logic [5:0] tb_crc_reg;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			crc_cnt_reg    <= 8'h00;
			crc_busy_reg   <= 1'b0;
			basic_lfsr_reg <= CRC_PRESET;
			tb_lfsr_reg    <= CRC_PRESET;
			basic_crc_reg  <= CRC_PRESET;
			tb_crc_reg     <= CRC_PRESET;
		end
		else if (line_start)
		begin
			crc_cnt_reg    <= 8'h00;
			crc_busy_reg   <= 1'b1;
			basic_lfsr_reg <= CRC_PRESET; // R10
			tb_lfsr_reg    <= CRC_PRESET; // R10
		end
		else if (crc_busy_reg)
		begin
			if (crc_cnt_reg < 8'(PAYLD_W))
				basic_lfsr_reg <= crc_step(basic_lfsr_reg, basic_raw[crc_cnt_reg[3:0]]); // R25
			if (crc_cnt_reg == 8'(PAYLD_W))
				basic_crc_reg <= basic_lfsr_reg; // R9
			tb_lfsr_reg <= crc_step(tb_lfsr_reg, tb_raw[crc_cnt_reg[6:0]]); // R13 R25
			if (crc_cnt_reg == 8'(TB_DATA_W - 1))
			begin
				tb_crc_reg   <= crc_step(tb_lfsr_reg, tb_raw[crc_cnt_reg[6:0]]); // R13
				crc_busy_reg <= 1'b0;
			end
			crc_cnt_reg <= crc_cnt_reg + 8'h01;
		end
	end

	// final words with or without computed check
	logic         basic_crc_on;
	logic [19:0]  basic_word;
	logic [133:0] tb_word;

	assign basic_crc_on = is_ntsc ? sd_reg[0][SD_CRC_EN_BIT] : ed_ctl_reg[ED_CRC_EN_BIT]; // R9
	assign basic_word   = basic_crc_on ? {basic_crc_reg, basic_raw[PAYLD_W-1:0]} // R11
		: basic_raw; // R12
	assign tb_word = typeb_reg[0][TYPEB_CRC_BIT] ? {tb_crc_reg, tb_raw[TB_DATA_W-1:0]} // R14
		: tb_raw; // R15

	// line selection and frame assembly
	logic         cgms_en;
	logic         tb_en;
	logic         hit;
	logic         hit_wss;
	logic [135:0] frame;
	logic [7:0]   frame_len;
	logic [3:0]   frame_bit_cyc;

	assign cgms_en = ed_ctl_reg[ED_CGMS_EN_BIT];
	assign tb_en   = typeb_reg[0][TYPEB_EN_BIT];

	always_comb
	begin
		hit           = 1'b0;
		hit_wss       = 1'b0;
		frame         = '0;
		frame_len     = 8'h00;
		frame_bit_cyc = BIT_CYC_HD;
		case (video_mode)
			MODE_NTSC:
			begin
				if ((line_num == LN_SD_ODD && !field_even && sd_reg[0][SD_ODD_EN_BIT])
					|| (line_num == LN_SD_EVEN && field_even && sd_reg[0][SD_EVEN_EN_BIT])) // R24
				begin
					hit           = 1'b1;
					frame[20:0]   = {basic_word, 1'b1}; // R23
					frame_len     = 8'(BASIC_W + 1);
					frame_bit_cyc = BIT_CYC_SD;
				end
			end
			MODE_PAL:
			begin
				if (line_num == LN_WSS && sd_reg[0][SD_WSS_EN_BIT]) // R16 R18
				begin
					hit           = 1'b1;
					hit_wss       = 1'b1;
					frame[66:0]   = {wss_bits, WSS_START, WSS_RUNIN}; // R17
					frame_len     = 8'(RUNIN_W + START_W + WSS_W);
					frame_bit_cyc = BIT_CYC_SD;
				end
			end
			MODE_625P:
			begin
				if (line_num == LN_625P && cgms_en) // R1
				begin
					hit           = 1'b1;
					frame[15:0]   = ed625_word; // R2
					frame_len     = 8'h10;
					frame_bit_cyc = BIT_CYC_ED;
				end
			end
			MODE_720P:
			begin
				if (line_num == LN_720P_CGMS && cgms_en) // R3
				begin
					hit         = 1'b1;
					frame[19:0] = basic_word;
					frame_len   = 8'(BASIC_W);
				end
				else if (line_num == LN_720P_TYPEB && tb_en) // R6
				begin
					hit          = 1'b1;
					frame[133:0] = tb_word;
					frame_len    = 8'(TB_W);
				end
			end
			MODE_1080I:
			begin
				if ((line_num == LN_1080_CG_A || line_num == LN_1080_CG_B) && cgms_en) // R4
				begin
					hit         = 1'b1;
					frame[19:0] = basic_word;
					frame_len   = 8'(BASIC_W);
				end
				else if ((line_num == LN_1080_TB_A || line_num == LN_1080_TB_B) && tb_en) // R7
				begin
					hit          = 1'b1;
					frame[133:0] = tb_word;
					frame_len    = 8'(TB_W);
				end
			end
			default:
			begin
				hit = 1'b0;
			end
		endcase
	end

	// line position counter
	logic [11:0] line_cyc_reg;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			line_cyc_reg <= 12'h000;
		else if (line_start)
			line_cyc_reg <= 12'h000;
		else if (line_cyc_reg != 12'hFFF)
			line_cyc_reg <= line_cyc_reg + 12'h001;
	end

	// serialiser
	vbi_state_t   state_reg;
	logic [135:0] shift_reg;
	logic [7:0]   bits_left_reg;
	logic [3:0]   bit_cyc_reg;
	logic [3:0]   cyc_cnt_reg;
	logic         wss_line_reg;
	logic         wss_blank_reg;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg     <= ST_IDLE;
			shift_reg     <= '0;
			bits_left_reg <= 8'h00;
			bit_cyc_reg   <= BIT_CYC_HD;
			cyc_cnt_reg   <= 4'h0;
			wss_line_reg  <= 1'b0;
			wss_blank_reg <= 1'b0;
		end
		else if (line_start)
		begin
			state_reg     <= hit ? ST_LEAD : ST_IDLE;
			shift_reg     <= frame;
			bits_left_reg <= frame_len;
			bit_cyc_reg   <= frame_bit_cyc;
			cyc_cnt_reg   <= 4'h0;
			wss_line_reg  <= hit_wss;
			wss_blank_reg <= hit_wss & blank_reg; // R20
		end
		else
		begin
			case (state_reg)
				ST_IDLE:
				begin
					cyc_cnt_reg <= 4'h0;
				end
				ST_LEAD:
				begin
					if (line_cyc_reg >= LEAD_CYC)
						state_reg <= ST_SEND;
				end
				ST_SEND:
				begin
					if (cyc_cnt_reg == bit_cyc_reg)
					begin
						cyc_cnt_reg   <= 4'h0;
						shift_reg     <= {1'b0, shift_reg[135:1]};
						bits_left_reg <= bits_left_reg - 8'h01;
						if (bits_left_reg == 8'h01)
							state_reg <= ST_TAIL;
					end
					else
					begin
						cyc_cnt_reg <= cyc_cnt_reg + 4'h1;
					end
				end
				ST_TAIL:
				begin
					if (!wss_line_reg || line_cyc_reg >= 12'(WSS_VIDEO_CYC - 1)) // R19
						state_reg <= ST_IDLE;
				end
				default:
				begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// luma output stage
	logic [9:0] luma_out_reg;
	logic       vbi_insert_reg;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			luma_out_reg   <= LVL_BLANK;
			vbi_insert_reg <= 1'b0;
		end
		else if (state_reg == ST_IDLE || line_start)
		begin
			luma_out_reg   <= luma_in; // R19
			vbi_insert_reg <= 1'b0;
		end
		else
		begin
			vbi_insert_reg <= 1'b1;
			if (state_reg == ST_SEND && !wss_blank_reg)
				luma_out_reg <= shift_reg[0] ? LVL_HIGH : LVL_LOW;
			else
				luma_out_reg <= LVL_BLANK; // R20
		end
	end

	assign prdata     = prdata_reg;
	assign pready     = pready_reg;
	assign pslverr    = pslverr_reg;
	assign luma_out   = luma_out_reg;
	assign vbi_insert = vbi_insert_reg;

endmodule

// File: inc/vbi_pkg.sv
// Function
// [R1] copy data goes on line 43 of 625p when the enhanced copy enable is set
// [R2] 625p copy payload comes only from the registers at indices 0x42 and 0x43
// [R3] 720p with copy enable carries the 20-bit copy word on line 24
// [R4] 1080i with copy enable carries the copy word on lines 19 and 582
// [R5] high definition copy payload comes from indices 0x41 to 0x43
// [R6] 720p with packet enable (0x5E bit 0) carries the Type B packet on line 23
// [R7] 1080i with packet enable carries the Type B packet on lines 18 and 581
// [R8] Type B packet contents come from indices 0x5E to 0x6E
// [R9] either copy check enable makes hardware compute the top six bits
// [R10] check generator uses x^6+x+1 with register preset to all ones
// [R11] computed check bits sit above the fourteen stored bits, twenty in all
// [R12] check disabled: all twenty bits sent as stored, software supplies them
// [R13] packet check enable (0x5E bit 1) computes six top bits from 128 stored bits
// [R14] computed packet check joins the 128 stored bits, 134 bits sent
// [R15] packet check disabled: all 134 bits sent as stored
// [R16] wide screen data only in PAL standard definition, on line 23
// [R17] fourteen wide screen bits follow a run-in and a start code
// [R18] wide screen data sent only while 0x99 bit 7 is one
// [R19] line 23 passes normal video from 42.5 us after sync falling edge
// [R20] 0xA1 bit 7 blanks the wide screen portion instead of sending data
// [R21] software codes aspect ratio, format and position in wide screen bits 3:0
// [R22] software sets the fixed meanings of wide screen bits 13:4
// [R23] standard copy data only in NTSC, twenty bits after a reference pulse
// [R24] standard copy data on line 20 odd and 283 even, fields chosen by 0x99[6:5]
// [R25] check generator steps serially from lowest bit, done before the line starts
package vbi_pkg;
	// register indices, byte address is four times the index
	localparam logic [9:0] IDX_ED_CTL    = 10'h032;
	localparam logic [9:0] IDX_HD_DATA0  = 10'h041;
	localparam logic [9:0] IDX_HD_DATA1  = 10'h042;
	localparam logic [9:0] IDX_HD_DATA2  = 10'h043;
	localparam logic [9:0] IDX_TYPEB_LO  = 10'h05E;
	localparam logic [9:0] IDX_TYPEB_HI  = 10'h06E;
	localparam logic [9:0] IDX_SD_CTL    = 10'h099;
	localparam logic [9:0] IDX_SD_DATA1  = 10'h09A;
	localparam logic [9:0] IDX_SD_DATA2  = 10'h09B;
	localparam logic [9:0] IDX_BLANK_CTL = 10'h0A1;
	localparam int TYPEB_REGS = 17;

	// bit positions
	localparam int ED_CGMS_EN_BIT  = 6;
	localparam int ED_CRC_EN_BIT   = 7;
	localparam int TYPEB_EN_BIT    = 0;
	localparam int TYPEB_CRC_BIT   = 1;
	localparam int SD_CRC_EN_BIT   = 4;
	localparam int SD_ODD_EN_BIT   = 5;
	localparam int SD_EVEN_EN_BIT  = 6;
	localparam int SD_WSS_EN_BIT   = 7;
	localparam int WSS_BLANK_BIT   = 7;

	// reset values
	localparam logic [7:0] REG_RESET = 8'h00;

	// video modes on the mode input
	localparam logic [2:0] MODE_NTSC  = 3'h0;
	localparam logic [2:0] MODE_PAL   = 3'h1;
	localparam logic [2:0] MODE_625P  = 3'h2;
	localparam logic [2:0] MODE_720P  = 3'h3;
	localparam logic [2:0] MODE_1080I = 3'h4;

	// target lines
	localparam logic [10:0] LN_SD_ODD     = 11'h014;
	localparam logic [10:0] LN_SD_EVEN    = 11'h11B;
	localparam logic [10:0] LN_WSS        = 11'h017;
	localparam logic [10:0] LN_625P       = 11'h02B;
	localparam logic [10:0] LN_720P_CGMS  = 11'h018;
	localparam logic [10:0] LN_720P_TYPEB = 11'h017;
	localparam logic [10:0] LN_1080_CG_A  = 11'h013;
	localparam logic [10:0] LN_1080_CG_B  = 11'h246;
	localparam logic [10:0] LN_1080_TB_A  = 11'h012;
	localparam logic [10:0] LN_1080_TB_B  = 11'h245;

	// word sizes
	localparam int BASIC_W   = 20;
	localparam int PAYLD_W   = 14;
	localparam int CHECK_W   = 6;
	localparam int TB_DATA_W = 128;
	localparam int TB_W      = 134;
	localparam int WSS_W     = 14;
	localparam int FRAME_W   = 136;
	localparam int RUNIN_W   = 29;
	localparam int START_W   = 24;
	localparam logic [5:0]  CRC_PRESET = 6'h3F;
	localparam logic [5:0]  CRC_TAPS   = 6'h03;
	localparam logic [28:0] WSS_RUNIN  = 29'h15555555;
	localparam logic [23:0] WSS_START  = 24'h0F0F0F;

	// timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int WSS_VIDEO_NS  = 42500;
	localparam int WSS_VIDEO_CYC = (WSS_VIDEO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [11:0] LEAD_CYC   = 12'h0DC;
	localparam logic [3:0]  BIT_CYC_SD = 4'hF;
	localparam logic [3:0]  BIT_CYC_ED = 4'h7;
	localparam logic [3:0]  BIT_CYC_HD = 4'h3;

	// output levels
	localparam logic [9:0] LVL_BLANK = 10'h040;
	localparam logic [9:0] LVL_LOW   = 10'h040;
	localparam logic [9:0] LVL_HIGH  = 10'h2D0;

	typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_SEND, ST_TAIL} vbi_state_t;
endpackage

// File: verification/vbi_inserter_bench.sv
`timescale 1ns/10ps
module vbi_inserter_bench
	import vbi_pkg::*;
;
	logic         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic         line_start = 1'b0, field_even = 1'b0, pready, pslverr, vbi_insert, err;
	logic         seen = 1'b0;
	logic [11:0]  paddr = 12'h000;
	logic [31:0]  pwdata = 32'h0, prdata;
	logic [2:0]   video_mode = 3'h7;
	logic [10:0]  line_num = 11'h000;
	logic [9:0]   luma_in = 10'h000, luma_out;
	logic [4:0]   rx_len = 5'h04;
	logic [7:0]   rd;
	logic [135:0] cap;
	int           fails = 0, tests_run = 0;

	vbi_inserter vbi_inserter_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .video_mode(video_mode), .line_start(line_start),
		.line_num(line_num), .field_even(field_even), .luma_in(luma_in),
		.luma_out(luma_out), .vbi_insert(vbi_insert));
	vbi_tv_rx vbi_tv_rx_inst (.pclk(pclk), .line_start(line_start), .luma_out(luma_out),
		.bit_len(rx_len), .cap(cap));

	always #10 pclk = ~pclk;
	// moving luma so pass-through is visible; flag any insertion in a line
	always @(posedge pclk)
	begin
		luma_in <= luma_in + 10'h001;
		if (line_start)
			seen <= 1'b0;
		else if (vbi_insert)
			seen <= 1'b1;
	end

	task print_verdict;
		$display("tests_run=%0d fails=%0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task check(input logic [135:0] s, input logic [135:0] e);
		tests_run++;
		if (s !== e)
		begin
			fails++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task apb(input logic w, input logic [9:0] i, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task run_line(input logic [2:0] m, input logic [10:0] ln, input logic fe, input logic [4:0] l);
		@(posedge pclk);
		video_mode <= m;
		line_num <= ln;
		field_even <= fe;
		rx_len <= l;
		line_start <= 1'b1;
		@(posedge pclk);
		line_start <= 1'b0;
		repeat (2200) @(posedge pclk);
	endtask

	function automatic logic [5:0] crc6(input logic [127:0] d, input int n);
		logic [5:0] c;
		logic       fb;
		c = CRC_PRESET;
		for (int i = 0; i < n; i++)
		begin
			fb = d[i] ^ c[5];
			c = {c[4:0], 1'b0} ^ (fb ? CRC_TAPS : 6'h00);
		end
		return c;
	endfunction

	task t_regs;
		apb(1'b0, IDX_ED_CTL, 8'h00);
		check({128'h0, rd}, 136'h0);
		apb(1'b1, IDX_BLANK_CTL, 8'hFF);
		apb(1'b0, IDX_BLANK_CTL, 8'h00);
		check({128'h0, rd}, 136'h80);
		apb(1'b1, IDX_BLANK_CTL, 8'h00);
		apb(1'b1, 10'h040, 8'h55);
		check({135'h0, err}, 136'h1);
		apb(1'b0, 10'h040, 8'h00);
		check({127'h0, err, rd}, 136'h100);
	endtask

	task t_hd;
		logic [13:0] p;
		p = {6'h2A, 8'h34};
		apb(1'b1, IDX_HD_DATA0, 8'h0F);
		apb(1'b1, IDX_HD_DATA1, 8'h6A);
		apb(1'b1, IDX_HD_DATA2, 8'h34);
		apb(1'b1, IDX_ED_CTL, 8'hC0);
		run_line(MODE_720P, LN_720P_CGMS, 1'b0, 5'h04);
		run_line(MODE_720P, LN_720P_CGMS, 1'b0, 5'h04);
		check({116'h0, cap[19:0]}, {116'h0, crc6({114'h0, p}, 14), p});
		run_line(MODE_720P, LN_720P_TYPEB, 1'b0, 5'h04);
		check({135'h0, seen}, 136'h0);
		apb(1'b1, IDX_ED_CTL, 8'h40);
		run_line(MODE_1080I, LN_1080_CG_A, 1'b0, 5'h04);
		check({116'h0, cap[19:0]}, {116'h0, 20'hF6A34});
		run_line(MODE_1080I, LN_1080_CG_B, 1'b1, 5'h04);
		check({116'h0, cap[19:0]}, {116'h0, 20'hF6A34});
		run_line(MODE_625P, LN_625P, 1'b0, 5'h08);
		check({120'h0, cap[15:0]}, {120'h0, 16'h6A34});
		run_line(MODE_625P, 11'h029, 1'b0, 5'h08);
		check({135'h0, seen}, 136'h0);
		run_line(MODE_720P, LN_1080_CG_A, 1'b0, 5'h04);
		check({135'h0, seen}, 136'h0);
		run_line(MODE_1080I, LN_720P_CGMS, 1'b0, 5'h04);
		check({135'h0, seen}, 136'h0);
		apb(1'b1, IDX_ED_CTL, 8'h00);
		run_line(MODE_625P, LN_625P, 1'b0, 5'h08);
		check({135'h0, seen}, 136'h0);
	endtask

	task t_typeb;
		logic [135:0] r;
		for (int j = 0; j < TYPEB_REGS; j++)
			r[j*8 +: 8] = (j == 0) ? 8'hA7 : 8'(j * 17);
		for (int j = 0; j < TYPEB_REGS; j++)
			apb(1'b1, IDX_TYPEB_LO + 10'(j), r[j*8 +: 8]);
		run_line(MODE_1080I, LN_1080_TB_B, 1'b0, 5'h04);
		run_line(MODE_1080I, LN_1080_TB_B, 1'b0, 5'h04);
		check({2'h0, cap[133:0]}, {2'h0, crc6(r[129:2], 128), r[129:2]});
		apb(1'b1, IDX_TYPEB_LO, 8'hA5);
		r[7:0] = 8'hA5;
		run_line(MODE_720P, LN_720P_TYPEB, 1'b0, 5'h04);
		check({2'h0, cap[133:0]}, {2'h0, r[135:2]});
		run_line(MODE_1080I, LN_720P_TYPEB, 1'b0, 5'h04);
		check({135'h0, seen}, 136'h0);
		apb(1'b1, IDX_TYPEB_LO, 8'h00);
	endtask

	task t_wss;
		apb(1'b1, IDX_SD_DATA1, 8'h2B);
		apb(1'b1, IDX_SD_DATA2, 8'h08);
		apb(1'b1, IDX_SD_CTL, 8'h80);
		run_line(MODE_PAL, LN_WSS, 1'b0, 5'h10);
		check({69'h0, cap[66:0]}, {69'h0, 14'h2B08, WSS_START, WSS_RUNIN});
		run_line(MODE_PAL, LN_SD_ODD, 1'b0, 5'h10);
		check({135'h0, seen}, 136'h0);
		apb(1'b1, IDX_BLANK_CTL, 8'h80);
		run_line(MODE_PAL, LN_WSS, 1'b0, 5'h10);
		check({68'h0, seen, cap[66:0]}, {68'h0, 1'b1, 67'h0});
		apb(1'b1, IDX_BLANK_CTL, 8'h00);
		run_line(MODE_NTSC, LN_WSS, 1'b0, 5'h10);
		check({135'h0, seen}, 136'h0);
		apb(1'b1, IDX_SD_CTL, 8'h00);
		run_line(MODE_PAL, LN_WSS, 1'b0, 5'h10);
		check({135'h0, seen}, 136'h0);
	endtask

	task t_ntsc;
		logic [13:0] p;
		p = {6'h2B, 8'h08};
		apb(1'b1, IDX_SD_CTL, 8'h7C);
		run_line(MODE_NTSC, LN_SD_ODD, 1'b0, 5'h10);
		run_line(MODE_NTSC, LN_SD_ODD, 1'b0, 5'h10);
		check({115'h0, cap[20:0]}, {115'h0, crc6({114'h0, p}, 14), p, 1'b1});
		run_line(MODE_NTSC, LN_SD_EVEN, 1'b1, 5'h10);
		check({115'h0, cap[20:0]}, {115'h0, crc6({114'h0, p}, 14), p, 1'b1});
		apb(1'b1, IDX_SD_CTL, 8'h20);
		run_line(MODE_NTSC, LN_SD_EVEN, 1'b1, 5'h10);
		check({135'h0, seen}, 136'h0);
	endtask

	initial
	begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_hd;
		t_typeb;
		t_wss;
		t_ntsc;
		print_verdict;
	end

	initial
	begin
		repeat (80000) @(posedge pclk);
		fails++;
		print_verdict;
	end
endmodule

bind vbi_inserter vbi_monitor vbi_monitor_inst (.pclk(pclk), .presetn(presetn),
	.video_mode(video_mode), .line_start(line_start), .line_num(line_num),
	.luma_in(luma_in), .luma_out(luma_out), .vbi_insert(vbi_insert));

// File: verification/vbi_monitor.sv
`timescale 1ns/10ps
module vbi_monitor
	import vbi_pkg::*;
(
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// video side
	input wire logic [2:0]  video_mode,
	input wire logic        line_start,
	input wire logic [10:0] line_num,
	input wire logic [9:0]  luma_in,
	input wire logic [9:0]  luma_out,
	input wire logic        vbi_insert
);
	localparam int END_CYC = WSS_VIDEO_CYC + 5;
	logic [11:0] cyc_reg;
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// cycles since the last line start, saturating
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cyc_reg <= 12'h000;
		else if (line_start)
			cyc_reg <= 12'h000;
		else if (cyc_reg != 12'hFFF)
			cyc_reg <= cyc_reg + 12'h001;
	end
	ins_start_a: assert property ($rose(vbi_insert) |-> $past(line_start, 2) || $past(line_start, 3))
		else $error("insertion began without a line start");
	p625_line_a: assert property (line_start && video_mode == MODE_625P && line_num != LN_625P
		|-> ##2 !vbi_insert [*2])
		else $error("625p insertion on a wrong line");
	p720_line_a: assert property (line_start && video_mode == MODE_720P && line_num != LN_720P_CGMS
		&& line_num != LN_720P_TYPEB |-> ##2 !vbi_insert [*2])
		else $error("720p insertion on a wrong line");
	i1080_line_a: assert property (line_start && video_mode == MODE_1080I
		&& line_num != LN_1080_CG_A && line_num != LN_1080_CG_B && line_num != LN_1080_TB_A
		&& line_num != LN_1080_TB_B |-> ##2 !vbi_insert [*2])
		else $error("1080i insertion on a wrong line");
	pal_line_a: assert property (line_start && video_mode == MODE_PAL && line_num != LN_WSS
		|-> ##2 !vbi_insert [*2])
		else $error("PAL insertion on a wrong line");
	ntsc_line_a: assert property (line_start && video_mode == MODE_NTSC && line_num != LN_SD_ODD
		&& line_num != LN_SD_EVEN |-> ##2 !vbi_insert [*2])
		else $error("NTSC insertion on a wrong line");
	luma_pass_a: assert property (!vbi_insert && $past(presetn) |-> luma_out == $past(luma_in))
		else $error("luma not passed through");
	ins_level_a: assert property (vbi_insert |-> luma_out == LVL_LOW || luma_out == LVL_HIGH)
		else $error("inserted level is neither low nor high");
	ins_end_a: assert property (cyc_reg >= 12'(END_CYC) |-> !vbi_insert)
		else $error("insertion ran past the video portion");
endmodule

// File: verification/vbi_tv_rx.sv
`timescale 1ns/10ps
module vbi_tv_rx
	import vbi_pkg::*;
(
	// video in
	input wire logic         pclk,
	input wire logic         line_start,
	input wire logic [9:0]   luma_out,
	input wire logic [4:0]   bit_len,
	// decoded frame, bit 0 first
	output logic     [135:0] cap
);
	logic [11:0] cnt_reg;
	int          k;
	// slices each bit near its centre
	always @(posedge pclk)
	begin
		k = int'(cnt_reg) - 221 - int'(bit_len) / 2;
		cnt_reg <= line_start ? 12'h000 : cnt_reg + 12'h001;
		if (line_start)
			cap <= '0;
		else if (k >= 0 && k % int'(bit_len) == 0 && k / int'(bit_len) < 136)
			cap[k / int'(bit_len)] <= luma_out > 10'h188;
	end
endmodule
